// [rtl/ofts_channel.sv]
// Output compare channel with fault, invert, tristate, cascade and trigger/sync control.
// Assumes all source, fault and cascade inputs are synchronous one-cycle events or levels.
// Function
// - Hold select set: fault held until source gone and flag cleared by software.
// - Hold select clear: fault ends when source gone and next period starts.
// - During fault the output is driven to the fault output level.
// - Drive select set forces pin output direction during fault.
// - Invert bit presents inverted compare output on the pin.
// - Cascade bit joins two channels into one 32-bit compare unit.
// - Select bit chooses trigger start or synchronisation to the source.
// - Trigger status set when triggered; with select bit set, timer held zero while it is clear.
// - Tristate bit floats the pin, otherwise compare output drives it.
// - Codes 1-9 compare channels, 11-15 timers, 16-17 reserved.
// - Captures, comparators, converter, measurement unit on 18-30; capture five at 10.
// - Code zero runs the channel unsynchronised.
// - Code all ones uses the channel itself as source.
// - Bits 11 to 9 read zero and ignore writes.
// - Clear mode set: trigger status clears when secondary value equals timer.
// - Fault handling active only in centre-aligned PWM mode.
// - Fault pin A governs channels 1-4, pin B channels 5-9.
`timescale 1ns/10ps
`include "ofts_map.svh"
module ofts_channel #(
  parameter int unsigned CHANNEL_NUM = 1
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        fault_pin_a,
  input  wire logic        fault_pin_b,
  input  wire logic [8:0]  compare_in,
  input  wire logic [4:0]  timer_in,
  input  wire logic [8:0]  capture_in,
  input  wire logic [2:0]  comparator_in,
  input  wire logic        converter_in,
  input  wire logic        charge_time_measurement_unit_in,
  input  wire logic        cascade_carry_in,
  input  wire logic        cascade_match_in,
  output logic             pin_out,
  output logic             pin_oe,
  output logic             match_out,
  output logic             carry_out
);

  function automatic logic [15:0] merge16(input logic [15:0] old_val,
                                          input logic [31:0] wdata,
                                          input logic [3:0]  be);
    merge16 = {be[1] ? wdata[15:8] : old_val[15:8],
               be[0] ? wdata[7:0]  : old_val[7:0]};
  endfunction : merge16

  // Control register two fields
  logic        flt_hold_q;
  logic        flt_level_q;
  logic        flt_drive_q;
  logic        invert_q;
  logic        cascade_q;
  logic        trig_sel_q;
  logic        trig_stat_q;
  logic        tristate_q;
  logic [4:0]  src_sel_q;
  // Control register one fields
  logic        flt_en_q;
  logic        flt_flag_q;
  logic        trig_clr_q;
  logic [2:0]  mode_q;
  logic [15:0] second_q;
  logic [15:0] period_q;
  logic [15:0] timer_q;
  logic [15:0] duty_q;
  logic        oc_q;
  logic        pin_out_q;
  logic        pin_oe_q;
  logic        match_q;
  logic        carry_q;
  logic [31:0] rdata_q;
  logic        wait_q;
  ofts_pkg::ofts_bus_state_t bus_q;
  ofts_pkg::ofts_flt_state_t flt_q;

  logic        wr_go;
  logic [15:0] ctrl2_rd;
  logic [15:0] ctrl1_rd;
  logic [15:0] ctrl2_wr;
  logic [15:0] ctrl1_wr;
  logic        wr_ctrl2;
  logic        wr_ctrl1;
  logic        step;
  logic        running;
  logic        wrap;
  logic        match;
  logic        fault_src;
  logic        pwm_mode;
  logic        sync_evt;
  logic        trig_evt;
  logic        trig_clr_hw;

  ofts_src_if src ();

  ofts_src_decode u_src_decode (
    .src (src)
  );

  // Event vector indexed by source code
  always_comb begin
    src.code         = src_sel_q;
    src.events       = '0;
    src.events[9:1]  = compare_in;
    src.events[10]   = capture_in[4];
    src.events[15:11] = timer_in;
    src.events[18]   = capture_in[6];
    src.events[19]   = capture_in[7];
    src.events[23:20] = capture_in[3:0];
    src.events[26:24] = comparator_in;
    src.events[27]   = converter_in;
    src.events[28]   = charge_time_measurement_unit_in;
    src.events[29]   = capture_in[5];
    src.events[30]   = capture_in[8];
    src.events[31]   = wrap;
  end

  assign ctrl2_rd = {flt_hold_q, flt_level_q, flt_drive_q, invert_q, 3'h0, cascade_q,
                     trig_sel_q, trig_stat_q, tristate_q, src_sel_q};
  assign ctrl1_rd = {8'h00, flt_en_q, 2'h0, flt_flag_q, trig_clr_q, mode_q};
  assign ctrl2_wr = merge16(ctrl2_rd, avs_writedata, avs_byteenable);
  assign ctrl1_wr = merge16(ctrl1_rd, avs_writedata, avs_byteenable);
  assign wr_go    = avs_write && (bus_q == ofts_pkg::OFTS_BUS_ACK);
  assign wr_ctrl2 = wr_go && (avs_address == `OFTS_OFF_CTRL2);
  assign wr_ctrl1 = wr_go && (avs_address == `OFTS_OFF_CTRL1);

  // Bus answer: one wait cycle, then waitrequest low for one cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bus_q  <= ofts_pkg::OFTS_BUS_IDLE;
      wait_q <= 1'b1;
    end else if (clk_en) begin
      case (bus_q)
        ofts_pkg::OFTS_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_q  <= ofts_pkg::OFTS_BUS_ACK;
            wait_q <= 1'b0;
          end
        end
        ofts_pkg::OFTS_BUS_ACK: begin
          bus_q  <= ofts_pkg::OFTS_BUS_IDLE;
          wait_q <= 1'b1;
        end
        default: begin
          bus_q  <= ofts_pkg::OFTS_BUS_IDLE;
          wait_q <= 1'b1;
        end
      endcase
    end
  end

  // Read data; unmapped offsets read zero
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (clk_en && avs_read && (bus_q == ofts_pkg::OFTS_BUS_IDLE)) begin
      case (avs_address)
        `OFTS_OFF_CTRL2:  rdata_q <= {16'h0000, ctrl2_rd};
        `OFTS_OFF_CTRL1:  rdata_q <= {16'h0000, ctrl1_rd};
        `OFTS_OFF_SECOND: rdata_q <= {16'h0000, second_q};
        `OFTS_OFF_PERIOD: rdata_q <= {16'h0000, period_q};
        `OFTS_OFF_TIMER:  rdata_q <= {16'h0000, timer_q};
        default:          rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Plain control fields of register two
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flt_hold_q  <= 1'b0;
      flt_level_q <= 1'b0;
      flt_drive_q <= 1'b0;
      invert_q    <= 1'b0;
      cascade_q   <= 1'b0;
      trig_sel_q  <= 1'b0;
      tristate_q  <= 1'b0;
      src_sel_q   <= `OFTS_RST_5;
    end else if (clk_en && wr_ctrl2) begin
      flt_hold_q  <= ctrl2_wr[`OFTS_B_FLT_HOLD];
      flt_level_q <= ctrl2_wr[`OFTS_B_FLT_LEVEL];
      flt_drive_q <= ctrl2_wr[`OFTS_B_FLT_DRIVE];
      invert_q    <= ctrl2_wr[`OFTS_B_INVERT];
      cascade_q   <= ctrl2_wr[`OFTS_B_CASCADE];
      trig_sel_q  <= ctrl2_wr[`OFTS_B_TRIG_SEL];
      tristate_q  <= ctrl2_wr[`OFTS_B_TRISTATE];
      src_sel_q   <= ctrl2_wr[`OFTS_F_SRC_HI:`OFTS_F_SRC_LO];
    end
  end

  // Register one fields and compare values
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flt_en_q   <= 1'b0;
      trig_clr_q <= 1'b0;
      mode_q     <= `OFTS_RST_3;
      second_q   <= `OFTS_RST_16;
      period_q   <= `OFTS_RST_16;
    end else if (clk_en) begin
      if (wr_ctrl1) begin
        flt_en_q   <= ctrl1_wr[`OFTS_B_FLT_EN];
        trig_clr_q <= ctrl1_wr[`OFTS_B_TRIG_CLR];
        mode_q     <= ctrl1_wr[`OFTS_F_MODE_HI:`OFTS_F_MODE_LO];
      end
      if (wr_go && (avs_address == `OFTS_OFF_SECOND)) begin
        second_q <= merge16(second_q, avs_writedata, avs_byteenable);
      end
      if (wr_go && (avs_address == `OFTS_OFF_PERIOD)) begin
        period_q <= merge16(period_q, avs_writedata, avs_byteenable);
      end
    end
  end

  // Time base control
  assign pwm_mode = (mode_q == `OFTS_MODE_EDGE_PWM) || (mode_q == `OFTS_MODE_CTR_PWM);
  assign running  = (mode_q != `OFTS_MODE_OFF) && (!trig_sel_q || trig_stat_q);
  assign step     = running && (!cascade_q || cascade_carry_in);
  assign wrap     = step && (timer_q == period_q);
  assign match    = running && (timer_q == duty_q) && (!cascade_q || cascade_match_in);
  assign sync_evt = !trig_sel_q && src.hit && !src.trig_only;
  assign trig_evt = trig_sel_q && src.hit;
  assign trig_clr_hw = trig_clr_q && (second_q == timer_q);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      timer_q <= `OFTS_RST_16;
    end else if (clk_en) begin
      if (!running) begin
        timer_q <= `OFTS_RST_16;
      end else if (sync_evt || wrap) begin
        timer_q <= `OFTS_RST_16;
      end else if (step) begin
        timer_q <= timer_q + 16'h0001;
      end
    end
  end

  // Trigger status: hardware set wins over any clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      trig_stat_q <= 1'b0;
    end else if (clk_en) begin
      if (trig_evt) begin
        trig_stat_q <= 1'b1;
      end else if (trig_stat_q && trig_clr_hw) begin
        trig_stat_q <= 1'b0;
      end else if (wr_ctrl2) begin
        trig_stat_q <= ctrl2_wr[`OFTS_B_TRIG_STAT];
      end
    end
  end

  // Duty buffer reloads at period end in PWM modes
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      duty_q <= `OFTS_RST_16;
    end else if (clk_en) begin
      if (!pwm_mode || wrap || !running) begin
        duty_q <= second_q;
      end
    end
  end

  // Raw compare output
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      oc_q <= 1'b0;
    end else if (clk_en) begin
      if (wr_ctrl1) begin
        oc_q <= (ctrl1_wr[`OFTS_F_MODE_HI:`OFTS_F_MODE_LO] == `OFTS_MODE_SET_LO);
      end else if (pwm_mode) begin
        if (wrap) begin
          oc_q <= (second_q != `OFTS_RST_16);
        end else if (match) begin
          oc_q <= 1'b0;
        end
      end else if (match) begin
        case (mode_q)
          `OFTS_MODE_OFF:    oc_q <= 1'b0;
          `OFTS_MODE_SET_HI: oc_q <= 1'b1;
          `OFTS_MODE_SET_LO: oc_q <= 1'b0;
          default:           oc_q <= !oc_q;
        endcase
      end
    end
  end

  // Fault source for this channel
  assign fault_src = flt_en_q && (mode_q == `OFTS_MODE_CTR_PWM) &&
                     ((CHANNEL_NUM <= `OFTS_FIRST_B_CH) ? fault_pin_a : fault_pin_b);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flt_flag_q <= 1'b0;
    end else if (clk_en) begin
      if (fault_src) begin
        flt_flag_q <= 1'b1;
      end else if (wr_ctrl1 && !ctrl1_wr[`OFTS_B_FLT_FLAG]) begin
        flt_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flt_q <= ofts_pkg::OFTS_FLT_RUN;
    end else if (clk_en) begin
      case (flt_q)
        ofts_pkg::OFTS_FLT_RUN: begin
          if (fault_src) begin
            flt_q <= ofts_pkg::OFTS_FLT_HELD;
          end
        end
        ofts_pkg::OFTS_FLT_HELD: begin
          if (mode_q != `OFTS_MODE_CTR_PWM) begin
            flt_q <= ofts_pkg::OFTS_FLT_RUN;
          end else if (flt_hold_q && !fault_src && !flt_flag_q) begin
            flt_q <= ofts_pkg::OFTS_FLT_RUN;
          end else if (!flt_hold_q && !fault_src && wrap) begin
            flt_q <= ofts_pkg::OFTS_FLT_RUN;
          end
        end
        default: flt_q <= ofts_pkg::OFTS_FLT_RUN;
      endcase
    end
  end

  // Pin level and direction
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_out_q <= 1'b0;
      pin_oe_q  <= 1'b0;
    end else if (clk_en) begin
      if (flt_q == ofts_pkg::OFTS_FLT_HELD) begin
        pin_out_q <= flt_level_q;
        pin_oe_q  <= flt_drive_q || !tristate_q;
      end else begin
        pin_out_q <= oc_q ^ invert_q;
        pin_oe_q  <= !tristate_q;
      end
    end
  end

  // Events offered to other channels
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      match_q <= 1'b0;
      carry_q <= 1'b0;
    end else if (clk_en) begin
      match_q <= match;
      carry_q <= wrap;
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign pin_out         = pin_out_q;
  assign pin_oe          = pin_oe_q;
  assign match_out       = match_q;
  assign carry_out       = carry_q;

endmodule : ofts_channel

// [rtl/ofts_map.svh]
// Register offsets, field positions, reset values and codes for the compare channel.
// Assumes byte addressing on a 32-bit Avalon-MM slave; one aligned word per register.
`ifndef OFTS_MAP_SVH
`define OFTS_MAP_SVH

`define OFTS_OFF_CTRL2     5'h00
`define OFTS_OFF_CTRL1     5'h04
`define OFTS_OFF_SECOND    5'h08
`define OFTS_OFF_PERIOD    5'h0c
`define OFTS_OFF_TIMER     5'h10

`define OFTS_RST_16        16'h0000
`define OFTS_RST_5         5'h00
`define OFTS_RST_3         3'h0

`define OFTS_B_FLT_HOLD    15
`define OFTS_B_FLT_LEVEL   14
`define OFTS_B_FLT_DRIVE   13
`define OFTS_B_INVERT      12
`define OFTS_B_CASCADE     8
`define OFTS_B_TRIG_SEL    7
`define OFTS_B_TRIG_STAT   6
`define OFTS_B_TRISTATE    5
`define OFTS_F_SRC_HI      4
`define OFTS_F_SRC_LO      0

`define OFTS_B_FLT_EN      7
`define OFTS_B_FLT_FLAG    4
`define OFTS_B_TRIG_CLR    3
`define OFTS_F_MODE_HI     2
`define OFTS_F_MODE_LO     0

`define OFTS_MODE_OFF      3'h0
`define OFTS_MODE_SET_HI   3'h1
`define OFTS_MODE_SET_LO   3'h2
`define OFTS_MODE_TOGGLE   3'h3
`define OFTS_MODE_EDGE_PWM 3'h6
`define OFTS_MODE_CTR_PWM  3'h7

`define OFTS_SRC_NONE      5'h00
`define OFTS_SRC_RSV_A     5'h10
`define OFTS_SRC_RSV_B     5'h11
`define OFTS_SRC_CAP5      5'h0a
`define OFTS_SRC_TRIG_LO   5'h12
`define OFTS_SRC_TRIG_HI   5'h1e
`define OFTS_SRC_SELF      5'h1f

`define OFTS_FIRST_B_CH    4

`endif

// [rtl/ofts_pkg.sv]
// Types shared by the compare channel modules.
// Assumes ofts_map.svh supplies every number except the state encodings, which are set here.
package ofts_pkg;
  typedef enum logic [1:0] {
    OFTS_FLT_RUN  = 2'b01,
    OFTS_FLT_HELD = 2'b10
  } ofts_flt_state_t;

  typedef enum logic [1:0] {
    OFTS_BUS_IDLE = 2'b01,
    OFTS_BUS_ACK  = 2'b10
  } ofts_bus_state_t;
endpackage : ofts_pkg

// [rtl/ofts_src_decode.sv]
// Source select decoder: picks the event of the chosen source.
// Assumes events are one-cycle pulses already aligned to the channel clock.
`timescale 1ns/10ps
`include "ofts_map.svh"
module ofts_src_decode (
  ofts_src_if.dec src
);
  function automatic logic is_trig_only(input logic [4:0] code);
    is_trig_only = (code == `OFTS_SRC_CAP5) ||
                   ((code >= `OFTS_SRC_TRIG_LO) && (code <= `OFTS_SRC_TRIG_HI));
  endfunction : is_trig_only

  always_comb begin
    src.trig_only = is_trig_only(src.code);
    if ((src.code == `OFTS_SRC_NONE) ||
        (src.code == `OFTS_SRC_RSV_A) ||
        (src.code == `OFTS_SRC_RSV_B)) begin
      src.hit = 1'b0;
    end else begin
      src.hit = src.events[src.code];
    end
  end
endmodule : ofts_src_decode

// [rtl/ofts_src_if.sv]
// Source selection bundle between the channel and its source decoder.
// Assumes the event vector is indexed by the 5-bit source code.
`timescale 1ns/10ps
interface ofts_src_if;
  logic [4:0]  code;
  logic [31:0] events;
  logic        hit;
  logic        trig_only;

  modport chan (output code, output events, input hit, input trig_only);
  modport dec  (input code, input events, output hit, output trig_only);
endinterface : ofts_src_if

// [verification/ofts_channel_assertions.sv]
// Checker for the compare channel bus handshake and pin control.
// Assumes it is bound to ofts_channel and sees only its ports.
`timescale 1ns/10ps
module ofts_chk #(
  parameter int unsigned CHANNEL_NUM = 1
) (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        clk_en,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        fault_pin_a,
  input wire logic        fault_pin_b,
  input wire logic        pin_out,
  input wire logic        pin_oe
);
  logic [15:0] c2_q;
  logic [7:0]  c1_q;
  logic [1:0]  quiet_q;
  logic        acc;
  logic        fsrc;
  logic        fcfg;
  assign acc  = clk_en && avs_write && !avs_waitrequest;
  assign fsrc = (CHANNEL_NUM <= 4) ? fault_pin_a : fault_pin_b;
  assign fcfg = c1_q[7] && c1_q[2:0] == 3'h7;
  // Shadow of the control registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      c2_q <= 16'h0000;
      c1_q <= 8'h00;
    end else if (acc && avs_address == 5'h00) begin
      if (avs_byteenable[0]) c2_q[7:0] <= avs_writedata[7:0];
      if (avs_byteenable[1]) c2_q[15:8] <= avs_writedata[15:8];
    end else if (acc && avs_address == 5'h04 && avs_byteenable[0]) begin
      c1_q <= avs_writedata[7:0];
    end
  end
  // Edges since the last write, pins lag one edge
  always_ff @(posedge clock) begin
    if (!rst_n) quiet_q <= 2'h0;
    else if (acc) quiet_q <= 2'h0;
    else if (clk_en && quiet_q != 2'h3) quiet_q <= quiet_q + 2'h1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n || !clk_en);
  chk_reset_idle: assert property (@(posedge clock) disable iff (1'b0)
    !rst_n && clk_en |=> avs_waitrequest && !pin_out && !pin_oe)
    else $error("outputs not idle after reset");
  chk_ack_next: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered next cycle");
  chk_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  chk_ctrl_readback: assert property (
    avs_read && !avs_waitrequest && avs_address == 5'h00 |->
    (avs_readdata[15:0] & 16'hf1bf) == (c2_q & 16'hf1bf) &&
    {avs_readdata[31:16], avs_readdata[11:9]} == 19'h0)
    else $error("control two readback wrong");
  chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 5'h10
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  chk_fault_level: assert property ($rose(fsrc) && fcfg |-> ##3 pin_out == c2_q[14])
    else $error("fault level not driven");
  chk_fault_drive: assert property ($rose(fsrc) && fcfg && c2_q[13] |-> ##3 pin_oe)
    else $error("fault did not force output");
  chk_tristate_off: assert property (
    c2_q[5] && c1_q[2:0] != 3'h7 && quiet_q != 2'h0 |-> !pin_oe)
    else $error("pin driven while tristated");
  chk_pin_driven: assert property (
    !c2_q[5] && c1_q[2:0] != 3'h0 && c1_q[2:0] != 3'h7 && quiet_q != 2'h0 |-> pin_oe)
    else $error("pin not driven");
  cover property ($rose(fsrc) && fcfg);
  cover property (avs_read && !avs_waitrequest && avs_address == 5'h10);
  cover property (c2_q[12] && quiet_q != 2'h0 && !pin_out);
endmodule : ofts_chk

bind ofts_channel ofts_chk #(.CHANNEL_NUM(CHANNEL_NUM)) u_ofts_chk (
  .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .fault_pin_a(fault_pin_a),
  .fault_pin_b(fault_pin_b), .pin_out(pin_out), .pin_oe(pin_oe));

// [verification/ofts_partner.sv]
// Far side of the channel: timers, captures, comparators and other channels.
// Assumes one fire pulse gives a one-cycle event on the source named by code.
`timescale 1ns/10ps
module ofts_partner (
  input wire logic        clock,
  input wire logic        fire,
  input wire logic [4:0]  code,
  input wire logic        carry,
  output logic     [8:0]  compare_in,
  output logic     [4:0]  timer_in,
  output logic     [8:0]  capture_in,
  output logic     [2:0]  comparator_in,
  output logic            converter_in,
  output logic            charge_time_measurement_unit_in,
  output logic            cascade_carry_in,
  output logic            cascade_match_in
);
  logic [31:0] ev_q = 32'h0;
  logic        carry_q = 1'b0;
  always_ff @(posedge clock) ev_q <= fire ? (32'h1 << code) : 32'h0;
  always_ff @(posedge clock) carry_q <= carry;
  assign compare_in       = ev_q[9:1];
  assign timer_in         = ev_q[15:11];
  assign capture_in       = {ev_q[30], ev_q[19:18], ev_q[29], ev_q[10], ev_q[23:20]};
  assign comparator_in    = ev_q[26:24];
  assign converter_in     = ev_q[27];
  assign charge_time_measurement_unit_in          = ev_q[28];
  assign cascade_carry_in = carry_q;
  assign cascade_match_in = carry_q;
endmodule : ofts_partner

// [verification/tb.sv]
// Self-checking bench for the compare channel control.
// Assumes channel 1, fault pin a, byte lanes 0 and 1 always enabled.
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module tb;
  typedef struct {logic [4:0] a; logic [15:0] d; logic [15:0] e;} ofts_row_t;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        fire = 1'b0;
  logic        carry = 1'b0;
  logic        flt = 1'b0;
  logic        fltb = 1'b0;
  logic        ce = 1'b1;
  logic [4:0]  adr = 5'h00;
  logic [4:0]  code = 5'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdv;
  logic [31:0] rdata;
  logic [31:0] rdv0;
  logic        wreq, pin_out, pin_oe, adc, meas, cc, cm, mo, co;
  logic [8:0]  cmp, cap;
  logic [4:0]  tmr;
  logic [2:0]  cpr;
  int          fail_count = 0;
  int          n_checks = 0;
  int          k = 0;
  int          m = 0;
  ofts_row_t   rows [7] = '{'{5'h00, 16'hff7e, 16'hf17e}, '{5'h00, 16'h0e00, 16'h0000},
    '{5'h00, 16'ha5b3, 16'ha1b3}, '{5'h08, 16'h1234, 16'h1234}, '{5'h0c, 16'hbeef, 16'hbeef},
    '{5'h14, 16'h5555, 16'h0000}, '{5'h1c, 16'hffff, 16'h0000}};

  always #10 clock = ~clock;

  ofts_channel #(.CHANNEL_NUM(1)) u_ofts_channel (.clock(clock), .rst_n(rst_n), .clk_en(ce),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(4'h3), .avs_readdata(rdata), .avs_waitrequest(wreq),
    .fault_pin_a(flt), .fault_pin_b(fltb), .compare_in(cmp), .timer_in(tmr),
    .capture_in(cap), .comparator_in(cpr), .converter_in(adc), .charge_time_measurement_unit_in(meas),
    .cascade_carry_in(cc), .cascade_match_in(cm), .pin_out(pin_out), .pin_oe(pin_oe),
    .match_out(mo), .carry_out(co));
  ofts_partner u_ofts_partner (.clock(clock), .fire(fire), .code(code), .carry(carry),
    .compare_in(cmp), .timer_in(tmr), .capture_in(cap), .comparator_in(cpr),
    .converter_in(adc), .charge_time_measurement_unit_in(meas), .cascade_carry_in(cc), .cascade_match_in(cm));

  task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clock);
    adr <= a;
    wd <= {16'h0000, d};
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clock);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) fail_count++;
    rdv = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test

  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    stop_test();
  end

  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    bus(0, 5'h00, 16'h0);
    `CHK(rdv, 32'h0)
    foreach (rows[i]) begin
      bus(1, rows[i].a, rows[i].d);
      bus(0, rows[i].a, 16'h0);
      `CHK(rdv, {16'h0, rows[i].e})
    end
    // Full duty, then invert and tristate
    bus(1, 5'h0c, 16'h0004);
    bus(1, 5'h08, 16'h0010);
    bus(1, 5'h00, 16'h0000);
    bus(1, 5'h04, 16'h0006);
    repeat (12) @(posedge clock);
    `CHK({pin_out, pin_oe}, 2'b11)
    repeat (10) begin
      @(posedge clock);
      k += co;
      m += mo;
    end
    `CHK(k, 2)
    `CHK(m, 0)
    bus(1, 5'h00, 16'h1000);
    repeat (3) @(posedge clock);
    `CHK(pin_out, 1'b0)
    bus(1, 5'h00, 16'h1020);
    repeat (3) @(posedge clock);
    `CHK(pin_oe, 1'b0)
    // Fault outside centre-aligned mode
    bus(1, 5'h04, 16'h0086);
    bus(1, 5'h00, 16'h6020);
    flt <= 1'b1;
    repeat (5) @(posedge clock);
    `CHK(pin_oe, 1'b0)
    flt <= 1'b0;
    // Held fault, high level, forced drive
    bus(1, 5'h04, 16'h0087);
    bus(1, 5'h00, 16'he020);
    fltb <= 1'b1;
    repeat (4) @(posedge clock);
    `CHK(pin_oe, 1'b0)
    fltb <= 1'b0;
    flt <= 1'b1;
    repeat (4) @(posedge clock);
    `CHK({pin_out, pin_oe}, 2'b11)
    flt <= 1'b0;
    repeat (12) @(posedge clock);
    `CHK(pin_oe, 1'b1)
    bus(0, 5'h04, 16'h0);
    `CHK(rdv[4], 1'b1)
    bus(1, 5'h04, 16'h0087);
    repeat (3) @(posedge clock);
    `CHK(pin_oe, 1'b0)
    // Fault ending at the next period, low level
    bus(1, 5'h00, 16'h2020);
    flt <= 1'b1;
    repeat (4) @(posedge clock);
    `CHK({pin_out, pin_oe}, 2'b01)
    flt <= 1'b0;
    repeat (12) @(posedge clock);
    `CHK(pin_oe, 1'b0)
    bus(1, 5'h04, 16'h0006);
    bus(1, 5'h0c, 16'h0010);
    // Every source code in trigger mode, own channel excluded
    for (int c = 2; c < 31; c++) begin
      bus(1, 5'h00, {8'h00, 3'h4, c[4:0]});
      bus(0, 5'h10, 16'h0);
      `CHK(rdv, 32'h0)
      fire <= 1'b1;
      code <= c[4:0];
      @(posedge clock);
      fire <= 1'b0;
      repeat (2) @(posedge clock);
      bus(0, 5'h00, 16'h0);
      `CHK(rdv[6], (c != 16 && c != 17))
    end
    bus(0, 5'h10, 16'h0);
    `CHK(rdv !== 32'h0, 1'b1)
    // Clock enable low freezes the running timer
    rdv0 = rdv;
    ce <= 1'b0;
    repeat (5) @(posedge clock);
    ce <= 1'b1;
    bus(0, 5'h10, 16'h0);
    `CHK(rdv - rdv0, 32'h3)
    // Status cleared by secondary match
    bus(1, 5'h08, 16'h0003);
    bus(1, 5'h04, 16'h000e);
    bus(1, 5'h00, 16'h008b);
    fire <= 1'b1;
    code <= 5'h0b;
    @(posedge clock);
    fire <= 1'b0;
    repeat (40) @(posedge clock);
    bus(0, 5'h00, 16'h0);
    `CHK(rdv[6], 1'b0)
    // Sync restarts the time base
    bus(1, 5'h04, 16'h0006);
    bus(1, 5'h00, 16'h000b);
    repeat (7) @(posedge clock);
    fire <= 1'b1;
    @(posedge clock);
    fire <= 1'b0;
    bus(0, 5'h10, 16'h0);
    `CHK(rdv < 32'h4, 1'b1)
    // Cascade: steps only on carry
    bus(1, 5'h04, 16'h0000);
    bus(1, 5'h00, 16'h0100);
    bus(1, 5'h04, 16'h0006);
    repeat (4) @(posedge clock);
    bus(0, 5'h10, 16'h0);
    `CHK(rdv, 32'h0)
    carry <= 1'b1;
    repeat (3) @(posedge clock);
    carry <= 1'b0;
    repeat (3) @(posedge clock);
    bus(0, 5'h10, 16'h0);
    `CHK(rdv, 32'h3)
    // Reset in mid-run
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    `CHK({pin_out, pin_oe}, 2'b00)
    rst_n <= 1'b1;
    bus(0, 5'h00, 16'h0);
    `CHK(rdv, 32'h0)
    `CHK(pin_oe, 1'b1)
    stop_test();
  end
endmodule : tb
